// >>> src/aux_adc_defs.svh
`ifndef AUX_ADC_DEFS_SVH
`define AUX_ADC_DEFS_SVH

`define AUX_CTRL_ADDR 32'h4003_0010
`define FILT_CFG_ADDR 32'h4003_0018
`define IRQ_STATUS_ADDR 32'h4003_0020
`define IRQ_ENABLE_ADDR 32'h4003_0024
`define IRQ_CLEAR_ADDR 32'h4003_0028
`define CONV_STATUS_ADDR 32'h4003_002c
`define AUX_CTRL_RESET 32'h0000_0000
`define FILT_CFG_RESET 32'h0000_0007
`define AUX_CTRL_WMASK 32'h000b_33d0
`define AUX_EN_BIT 19
`define BUFBP_HI 17
`define BUFBP_LO 16
`define DIAG_HI 13
`define DIAG_LO 12
`define CODE_BIT 9
`define CHAN_HI 8
`define CHAN_LO 6
`define REF_BIT 4
`define SETTLE_CYCLES 64
`define FRAME_CYCLES 16
`define IRQ_BITS 3

`endif

// >>> src/aux_adc_pkg.sv
package aux_adc_pkg;
    typedef enum logic [1:0] {
        AUX_OFF = 2'b00,
        AUX_WAIT_SYNC = 2'b01,
        AUX_SETTLE = 2'b10,
        AUX_RUN = 2'b11
    } aux_state_t;
endpackage

// >>> src/frame_tick.sv
`timescale 1ns/1ps
`include "aux_adc_defs.svh"
module frame_tick #(
    parameter int PERIOD = `FRAME_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic restart,
    output logic tick
);
    localparam int W = $clog2(PERIOD);
    logic [W-1:0] cnt_reg;

    initial begin
        if (PERIOD < 2) $error("frame_tick period must be at least 2");
    end

    // restart realigns every converter to a fresh frame
    always_ff @(posedge aclk) begin
        if (!aresetn || restart) begin
            cnt_reg <= '0;
        end else if (cnt_reg == W'(PERIOD - 1)) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign tick = aresetn && !restart && (cnt_reg == W'(PERIOD - 1));
endmodule

// >>> src/aux_adc_control_regs.sv
`timescale 1ns/1ps
`include "aux_adc_defs.svh"
// Overview of operation
// RL1 - every write to aux control resets and restarts the aux converter
// RL2 - aux restart waits for the shared frame; current converter keeps running
// RL3 - no aux result valid until the full filter settling time passes
// RL4 - enable bit 19 runs aux; clearing powers down and clears both ready flags
// RL5 - software writes zero to reserved control bits
// RL6 - bits 17:16 select which input buffers are bypassed
// RL7 - both-buffers bypass is for hibernate only, software's duty
// RL8 - bits 13:12 steer the 50 uA diagnostic current
// RL9 - bit 9 selects bipolar or unipolar coding, unipolar clamps negatives
// RL10 - bits 8:6 pick one of eight converter input pairs
// RL11 - bit 4 picks internal 1.2 V or 1.8 V supply reference
// RL12 - aux control at its fixed address, resets to zero, aux disabled
// RL13 - filter config at its fixed address, resets to seven
// RL14 - a filter config write resets every converter
// RL15 - the write-triggered reset happens even when value is unchanged
module aux_adc_control_regs
    import aux_adc_pkg::*;
#(
    parameter int SETTLE = `SETTLE_CYCLES,
    parameter int FRAME = `FRAME_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic aux_conversion_done,
    input wire logic [23:0] aux_raw_result,
    output logic aux_enable,
    output logic aux_converter_reset,
    output logic current_converter_reset,
    output logic [1:0] input_buffer_bypass,
    output logic [1:0] diag_current_select,
    output logic output_coding_select,
    output logic [2:0] input_channel_select,
    output logic reference_select,
    output logic [31:0] filter_config,
    output logic aux_result_ready_a,
    output logic aux_result_ready_b,
    output logic [23:0] aux_result,
    output logic irq
);
    localparam int SW = $clog2(SETTLE + 1);

    initial begin
        if (SETTLE < 1) $error("settle count must be at least 1");
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    // write channel capture
    logic aw_held_reg, w_held_reg;
    logic [31:0] awaddr_reg, wdata_reg;
    logic [3:0] wstrb_reg;
    logic do_write;

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= 32'h0000_0000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end
    end

    logic wr_aux, wr_filt, wr_ien, wr_iclr, wr_ok;
    assign wr_aux = do_write && awaddr_reg == `AUX_CTRL_ADDR;
    assign wr_filt = do_write && awaddr_reg == `FILT_CFG_ADDR;
    assign wr_ien = do_write && awaddr_reg == `IRQ_ENABLE_ADDR;
    assign wr_iclr = do_write && awaddr_reg == `IRQ_CLEAR_ADDR;
    assign wr_ok = wr_aux || wr_filt || wr_ien || wr_iclr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // registers
    logic [31:0] aux_ctrl_reg, filt_reg;
    logic [`IRQ_BITS-1:0] ien_reg, ists_reg;
    logic [31:0] aux_ctrl_wr;
    logic en_new;

    // reserved bits held at zero
    assign aux_ctrl_wr = merge(aux_ctrl_reg, wdata_reg, wstrb_reg) & `AUX_CTRL_WMASK;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aux_ctrl_reg <= `AUX_CTRL_RESET; // RL12
        end else if (wr_aux) begin
            aux_ctrl_reg <= aux_ctrl_wr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filt_reg <= `FILT_CFG_RESET; // RL13
        end else if (wr_filt) begin
            filt_reg <= merge(filt_reg, wdata_reg, wstrb_reg);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ien_reg <= '0;
        end else if (wr_ien) begin
            ien_reg <= wdata_reg[`IRQ_BITS-1:0];
        end
    end

    assign aux_enable = aux_ctrl_reg[`AUX_EN_BIT]; // RL4
    // enable as it stands after a write committing this cycle
    assign en_new = wr_aux ? aux_ctrl_wr[`AUX_EN_BIT] : aux_enable;
    assign input_buffer_bypass = aux_ctrl_reg[`BUFBP_HI:`BUFBP_LO]; // RL6
    assign diag_current_select = aux_ctrl_reg[`DIAG_HI:`DIAG_LO]; // RL8
    assign output_coding_select = aux_ctrl_reg[`CODE_BIT]; // RL9
    assign input_channel_select = aux_ctrl_reg[`CHAN_HI:`CHAN_LO]; // RL10
    assign reference_select = aux_ctrl_reg[`REF_BIT]; // RL11
    assign filter_config = filt_reg;

    // converter resets on every filter config write, aux also on every aux control write, regardless of value
    logic restart_all;
    assign restart_all = wr_filt; // RL14 RL15
    assign current_converter_reset = restart_all; // RL14
    assign aux_converter_reset = wr_aux || restart_all; // RL1 RL15

    logic frame_tick_w;
    frame_tick #(.PERIOD(FRAME)) u_frame (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(restart_all),
        .tick(frame_tick_w)
    );

    // aux sequencer
    aux_state_t state_reg, state_next;
    logic [SW-1:0] settle_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            AUX_OFF: if (aux_enable) state_next = AUX_WAIT_SYNC;
            AUX_WAIT_SYNC: if (frame_tick_w) state_next = AUX_SETTLE; // RL2
            AUX_SETTLE: if (settle_reg == SW'(SETTLE - 1) && frame_tick_w) state_next = AUX_RUN;
            AUX_RUN: state_next = AUX_RUN;
        endcase
        if (aux_converter_reset) state_next = AUX_WAIT_SYNC; // RL1
        if (!en_new) state_next = AUX_OFF; // RL4
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= AUX_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || state_reg != AUX_SETTLE) begin
            settle_reg <= '0;
        end else if (frame_tick_w && settle_reg != SW'(SETTLE - 1)) begin
            settle_reg <= settle_reg + 1'b1; // RL3
        end
    end

    // results, gated by settling and unipolar clamp
    logic result_ev, rdy_clr;
    assign result_ev = state_reg == AUX_RUN && aux_conversion_done && !aux_converter_reset;
    assign rdy_clr = !aux_enable || aux_converter_reset;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aux_result <= 24'h00_0000;
        end else if (result_ev) begin
            aux_result <= (output_coding_select && aux_raw_result[23]) ? 24'h00_0000
                                                                       : aux_raw_result; // RL9
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || rdy_clr) begin
            aux_result_ready_a <= 1'b0; // RL4
            aux_result_ready_b <= 1'b0; // RL4
        end else if (result_ev) begin
            aux_result_ready_a <= 1'b1; // RL3
            aux_result_ready_b <= 1'b1;
        end
    end

    // interrupts: 0 result, 1 aux restart, 2 all restart; set wins over clear
    logic [`IRQ_BITS-1:0] ev;
    assign ev = {restart_all, aux_converter_reset, result_ev};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ists_reg <= '0;
        end else begin
            ists_reg <= (ists_reg & ~(wr_iclr ? wdata_reg[`IRQ_BITS-1:0] : '0)) | ev;
        end
    end
    assign irq = |(ists_reg & ien_reg);

    // read channel
    logic [31:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            `AUX_CTRL_ADDR: rd_val = aux_ctrl_reg;
            `FILT_CFG_ADDR: rd_val = filt_reg;
            `IRQ_STATUS_ADDR: rd_val = {29'h0, ists_reg};
            `IRQ_ENABLE_ADDR: rd_val = {29'h0, ien_reg};
            `IRQ_CLEAR_ADDR: rd_val = 32'h0000_0000;
            `CONV_STATUS_ADDR: rd_val = {28'h0, aux_result_ready_b, aux_result_ready_a,
                                         state_reg};
            default: rd_ok = 1'b0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    property p_aux_restart;
        @(posedge aclk) disable iff (!aresetn)
        wr_aux && wdata_reg[`AUX_EN_BIT] |=> state_reg == AUX_WAIT_SYNC;
    endproperty
    a_aux_restart: assert property (p_aux_restart) else $error("aux not restarted"); // RL1

    property p_no_cur_reset;
        @(posedge aclk) disable iff (!aresetn)
        wr_aux && !wr_filt |-> !current_converter_reset;
    endproperty
    a_no_cur_reset: assert property (p_no_cur_reset) else $error("current reset"); // RL2

    property p_settle;
        @(posedge aclk) disable iff (!aresetn)
        $rose(aux_result_ready_a) |-> $past(state_reg) == AUX_RUN;
    endproperty
    a_settle: assert property (p_settle) else $error("early result"); // RL3

    property p_disable_clears;
        @(posedge aclk) disable iff (!aresetn)
        !aux_enable && !(wr_aux && wdata_reg[`AUX_EN_BIT])
            |=> !aux_result_ready_a && !aux_result_ready_b && state_reg == AUX_OFF;
    endproperty
    a_disable_clears: assert property (p_disable_clears) else $error("ready not cleared"); // RL4

    property p_fields;
        @(posedge aclk) disable iff (!aresetn)
        wr_aux && wstrb_reg == 4'hf |=> input_buffer_bypass == $past(wdata_reg[17:16])
            && diag_current_select == $past(wdata_reg[13:12])
            && input_channel_select == $past(wdata_reg[8:6]);
    endproperty
    a_fields: assert property (p_fields) else $error("field mismatch"); // RL6

    property p_unipolar;
        @(posedge aclk) disable iff (!aresetn)
        result_ev && output_coding_select && aux_raw_result[23] |=> aux_result == 24'h0;
    endproperty
    a_unipolar: assert property (p_unipolar) else $error("no clamp"); // RL9

    property p_filt_all;
        @(posedge aclk) disable iff (!aresetn)
        wr_filt |-> current_converter_reset && aux_converter_reset;
    endproperty
    a_filt_all: assert property (p_filt_all) else $error("filter write reset"); // RL14

    property p_reset_vals;
        @(posedge aclk) !aresetn |=> aux_ctrl_reg == 32'h0 && filt_reg == 32'h7 && !aux_enable;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset value"); // RL12

    c_restart: cover property (@(posedge aclk) disable iff (!aresetn) wr_aux ##[1:300] result_ev);
    c_filt: cover property (@(posedge aclk) disable iff (!aresetn) wr_filt);
    c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
`include "aux_adc_defs.svh"
module tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = '0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [31:0] s_axi_araddr = '0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic aux_conversion_done = 1'b0;
    logic [23:0] aux_raw_result = '0;
    logic aux_enable, aux_converter_reset, current_converter_reset;
    logic [1:0] input_buffer_bypass, diag_current_select;
    logic output_coding_select, reference_select;
    logic [2:0] input_channel_select;
    logic [31:0] filter_config;
    logic aux_result_ready_a, aux_result_ready_b, irq;
    logic [23:0] aux_result;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    int aux_rst_cnt = 0;
    int cur_rst_cnt = 0;
    logic [31:0] rdat;
    logic [1:0] resp;

    aux_adc_control_regs #(.SETTLE(2), .FRAME(4)) DUT (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .aux_conversion_done, .aux_raw_result, .aux_enable,
        .aux_converter_reset, .current_converter_reset, .input_buffer_bypass,
        .diag_current_select, .output_coding_select, .input_channel_select,
        .reference_select, .filter_config, .aux_result_ready_a, .aux_result_ready_b,
        .aux_result, .irq);

    always #2.5 aclk = ~aclk;

    // restart pulses sampled mid-cycle where they are settled
    always @(negedge aclk) begin
        if (aresetn) begin
            aux_rst_cnt += int'(aux_converter_reset);
            cur_rst_cnt += int'(current_converter_reset);
        end
    end

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tk;
        r = 2'b11;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 200; n++) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tk = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tk) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tk;
        d = 'x;
        r = 2'b11;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 200; n++) begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tk = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tk) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic sample(input logic [23:0] v);
        @(posedge aclk);
        aux_conversion_done <= 1'b1;
        aux_raw_result <= v;
        @(posedge aclk);
        aux_conversion_done <= 1'b0;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
    endtask

    task automatic t_reset_values();
        rd(`AUX_CTRL_ADDR, rdat, resp);
        chk(rdat, 32'h0000_0000);
        chk({30'h0, resp}, 32'h0000_0000);
        rd(`FILT_CFG_ADDR, rdat, resp);
        chk(rdat, 32'h0000_0007);
        chk(filter_config, 32'h0000_0007);
        chk({31'h0, aux_enable}, 32'h0000_0000);
        $display("test reset_values done");
    endtask

    task automatic t_fields();
        logic [31:0] v;
        for (int i = 0; i < 8; i++) begin
            v = 32'h0;
            v[17:16] = 2'(i);
            v[13:12] = 2'(i + 1);
            v[9] = i[0];
            v[8:6] = 3'(i);
            v[4] = i[1];
            wr(`AUX_CTRL_ADDR, v, resp);
            @(negedge aclk);
            chk({30'h0, input_buffer_bypass}, {30'h0, v[17:16]});
            chk({30'h0, diag_current_select}, {30'h0, v[13:12]});
            chk({31'h0, output_coding_select}, {31'h0, v[9]});
            chk({29'h0, input_channel_select}, {29'h0, v[8:6]});
            chk({31'h0, reference_select}, {31'h0, v[4]});
        end
        wr(`AUX_CTRL_ADDR, 32'hfffe_ffff, resp);
        rd(`AUX_CTRL_ADDR, rdat, resp);
        chk(rdat, 32'h000a_33d0);
        chk({31'h0, aux_enable}, 32'h0000_0001);
        $display("test fields done");
    endtask

    task automatic t_restart();
        int a0, c0;
        a0 = aux_rst_cnt;
        c0 = cur_rst_cnt;
        wr(`AUX_CTRL_ADDR, 32'h0008_0000, resp);
        wr(`AUX_CTRL_ADDR, 32'h0008_0000, resp);
        chk(32'(aux_rst_cnt - a0), 32'h2);
        chk(32'(cur_rst_cnt - c0), 32'h0);
        wr(`FILT_CFG_ADDR, 32'h0000_0123, resp);
        wr(`FILT_CFG_ADDR, 32'h0000_0123, resp);
        chk(32'(aux_rst_cnt - a0), 32'h4);
        chk(32'(cur_rst_cnt - c0), 32'h2);
        rd(`FILT_CFG_ADDR, rdat, resp);
        chk(rdat, 32'h0000_0123);
        chk(filter_config, 32'h0000_0123);
        $display("test restart done");
    endtask

    task automatic t_settle();
        wr(`IRQ_ENABLE_ADDR, 32'h0000_0001, resp);
        wr(`IRQ_CLEAR_ADDR, 32'h0000_0007, resp);
        wr(`AUX_CTRL_ADDR, 32'h0008_0000, resp);
        sample(24'hfffff0);
        chk({30'h0, aux_result_ready_b, aux_result_ready_a}, 32'h0);
        repeat (30) @(posedge aclk);
        sample(24'hfffff0);
        chk({30'h0, aux_result_ready_b, aux_result_ready_a}, 32'h3);
        chk({8'h0, aux_result}, 32'h00ff_fff0);
        chk({31'h0, irq}, 32'h1);
        wr(`IRQ_ENABLE_ADDR, 32'h0000_0000, resp);
        chk({31'h0, irq}, 32'h0);
        wr(`IRQ_ENABLE_ADDR, 32'h0000_0001, resp);
        wr(`IRQ_CLEAR_ADDR, 32'h0000_0001, resp);
        chk({31'h0, irq}, 32'h0);
        wr(`AUX_CTRL_ADDR, 32'h0008_0200, resp);
        @(negedge aclk);
        chk({30'h0, aux_result_ready_b, aux_result_ready_a}, 32'h0);
        repeat (30) @(posedge aclk);
        sample(24'h800001);
        chk({8'h0, aux_result}, 32'h0);
        wr(`AUX_CTRL_ADDR, 32'h0000_0000, resp);
        @(negedge aclk);
        chk({30'h0, aux_result_ready_b, aux_result_ready_a}, 32'h0);
        chk({31'h0, aux_enable}, 32'h0);
        $display("test settle done");
    endtask

    task automatic t_unmapped();
        rd(32'h4003_0030, rdat, resp);
        chk({30'h0, resp}, 32'h2);
        wr(32'h4003_0034, 32'h0000_0055, resp);
        chk({30'h0, resp}, 32'h2);
        $display("test unmapped done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_values();
        t_fields();
        t_restart();
        t_settle();
        t_unmapped();
        final_report();
    end
endmodule
